/* hdl/output_pulse_timers.sv */
`timescale 1ns/1ps
module output_pulse_timers
    import output_pulse_timers_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic exposure_start,
    output logic [3:0] out_line
);
    // =====================================================================
    // types and state
    // =====================================================================
    typedef enum logic [2:0] {
        T_IDLE = 3'b001,
        T_DELAY = 3'b010,
        T_DURATION = 3'b100
    } phase_t;

    typedef struct packed {
        logic [3:0][4:0] presc;       // per-timer us prescaler, restarted at start
        logic [1:0] sel;              // selected timer
        logic [3:0][1:0] src;         // start source per timer
        logic [3:0][11:0] dly;        // delay counts
        logic [3:0][11:0] dur;        // duration counts
        logic [15:0] dly_base;        // shared delay base, us
        logic [15:0] dur_base;        // shared duration base, us
        logic [3:0] invert;           // per-line inverter
        logic [3:0] user_sel;         // line driven by user value
        logic [3:0] user_val;         // user value per line
        logic [3:0][2:0] phase;       // timer phase
        logic [3:0][11:0] cnt;        // raw-count progress
        logic [3:0][15:0] sub;        // microseconds within one base step
        logic [3:0] timer_out;        // timer signal before the inverter
        logic [3:0] line;             // registered line level
        logic exp_s1;                 // synchroniser stage one
        logic exp_s2;                 // synchroniser stage two
        logic exp_d;                  // edge detect history
        logic aw_ok;                  // write address held
        logic [7:0] aw_addr;
        logic w_ok;                   // write data held
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t cur;
    state_t next_cur;

    // =====================================================================
    // helpers
    // =====================================================================
    // count times base, the absolute time in us
    function automatic logic [31:0] abs_time(input logic [11:0] c, input logic [15:0] b);
        // widen before the product so a full count times a large base keeps its top bits
        abs_time = {4'h0, ABS_W'(ABS_W'(c) * ABS_W'(b))};
    endfunction : abs_time

    // nearest raw count for an absolute time, clamped to lo..max
    function automatic logic [11:0] to_count(input logic [31:0] t, input logic [15:0] b,
                                             input logic [11:0] lo);
        logic [32:0] q;
        q = 33'((33'(t) + 33'(b >> 1)) / 33'(b));  // round to nearest
        if (q > 33'(COUNT_MAX)) begin
            to_count = COUNT_MAX;
        end else if (q < 33'(lo)) begin
            to_count = lo;
        end else begin
            to_count = q[11:0];
        end
    endfunction : to_count

    // 16-bit base write, never below the minimum
    function automatic logic [15:0] to_base(input logic [31:0] d);
        to_base = (d[31:16] != 16'h0000) ? 16'hffff :
                  (d[15:0] < BASE_MIN) ? BASE_MIN : d[15:0];
    endfunction : to_base

    logic [3:0] tick;  // one-cycle us tick per timer
    logic start_evt;
    logic wr_fire;
    logic [31:0] wd;
    // own prescaler per timer: a shared one would clip up to 1 us off a period
    assign tick = {cur.presc[3] == TICK_LAST, cur.presc[2] == TICK_LAST,
                   cur.presc[1] == TICK_LAST, cur.presc[0] == TICK_LAST};
    assign start_evt = cur.exp_s2 & ~cur.exp_d;
    assign wr_fire = cur.aw_ok & cur.w_ok & ~cur.bvalid;
    assign wd = cur.w_data & {{8{cur.w_strb[3]}}, {8{cur.w_strb[2]}},
                              {8{cur.w_strb[1]}}, {8{cur.w_strb[0]}}};

    // =====================================================================
    // next-state logic
    // =====================================================================
    always_comb begin
        next_cur = cur;
        // synchroniser; only stage two feeds the edge detector
        next_cur.exp_s1 = exposure_start;
        next_cur.exp_s2 = cur.exp_s1;
        next_cur.exp_d = cur.exp_s2;
        // timers
        for (int i = 0; i < 4; i++) begin
            next_cur.presc[i] = tick[i] ? 5'h00 : cur.presc[i] + 5'h01;
            case (cur.phase[i])
                T_IDLE: begin
                    // start only when the exposure-start source is chosen
                    if (start_evt && cur.src[i] == SRC_EXPOSURE_START) begin
                        next_cur.cnt[i] = 12'h000;
                        next_cur.sub[i] = 16'h0000;
                        next_cur.presc[i] = 5'h00;  // first us counted from the start
                        if (cur.dly[i] == 12'h000) begin
                            next_cur.phase[i] = T_DURATION;  // zero delay: straight high
                            next_cur.timer_out[i] = 1'b1;
                        end else begin
                            next_cur.phase[i] = T_DELAY;
                        end
                    end
                end
                T_DELAY: begin
                    // a new start is ignored here
                    if (tick[i]) begin
                        if (cur.sub[i] + 16'h0001 >= cur.dly_base) begin
                            next_cur.sub[i] = 16'h0000;
                            if (cur.cnt[i] + 12'h001 >= cur.dly[i]) begin
                                next_cur.cnt[i] = 12'h000;
                                next_cur.phase[i] = T_DURATION;
                                next_cur.timer_out[i] = 1'b1;
                            end else begin
                                next_cur.cnt[i] = cur.cnt[i] + 12'h001;
                            end
                        end else begin
                            next_cur.sub[i] = cur.sub[i] + 16'h0001;
                        end
                    end
                end
                T_DURATION: begin
                    if (tick[i]) begin
                        if (cur.sub[i] + 16'h0001 >= cur.dur_base) begin
                            next_cur.sub[i] = 16'h0000;
                            if (cur.cnt[i] + 12'h001 >= cur.dur[i]) begin
                                next_cur.phase[i] = T_IDLE;
                                next_cur.timer_out[i] = 1'b0;
                            end else begin
                                next_cur.cnt[i] = cur.cnt[i] + 12'h001;
                            end
                        end else begin
                            next_cur.sub[i] = cur.sub[i] + 16'h0001;
                        end
                    end
                end
                default: begin
                    next_cur.phase[i] = T_IDLE;
                    next_cur.timer_out[i] = 1'b0;
                end
            endcase
        end

        // line n from timer n or user value, then inverter
        for (int i = 0; i < 4; i++) begin
            next_cur.line[i] = (cur.user_sel[i] ? cur.user_val[i] :
                                cur.timer_out[i]) ^ cur.invert[i];
        end

        // AXI4-Lite write: address and data in either order
        if (s_axi_awvalid && !cur.aw_ok && !cur.bvalid) begin
            next_cur.aw_ok = 1'b1;
            next_cur.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.w_ok && !cur.bvalid) begin
            next_cur.w_ok = 1'b1;
            next_cur.w_data = s_axi_wdata;
            next_cur.w_strb = s_axi_wstrb;
        end
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_cur.aw_ok = 1'b0;
            next_cur.w_ok = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp = RESP_OKAY;
            // source, count and absolute-time writes target the selected timer
            if (cur.aw_addr == ADDR_TIMER_SEL) begin
                next_cur.sel = wd[1:0];
            end else if (cur.aw_addr == ADDR_START_SRC) begin
                next_cur.src[cur.sel] = (wd[1:0] == SRC_EXPOSURE_START) ?
                                        SRC_EXPOSURE_START : SRC_OFF;
            end else if (cur.aw_addr == ADDR_DELAY_COUNT) begin
                next_cur.dly[cur.sel] = wd[11:0];
            end else if (cur.aw_addr == ADDR_DELAY_BASE) begin
                next_cur.dly_base = to_base(wd);
            end else if (cur.aw_addr == ADDR_DELAY_ABS) begin
                next_cur.dly[cur.sel] = to_count(wd, cur.dly_base, 12'h000);
            end else if (cur.aw_addr == ADDR_DUR_COUNT) begin
                // zero is illegal, so it is raised to one
                next_cur.dur[cur.sel] = (wd[11:0] == 12'h000) ? 12'h001 : wd[11:0];
            end else if (cur.aw_addr == ADDR_DUR_BASE) begin
                next_cur.dur_base = to_base(wd);
            end else if (cur.aw_addr == ADDR_DUR_ABS) begin
                next_cur.dur[cur.sel] = to_count(wd, cur.dur_base, 12'h001);
            end else if (cur.aw_addr == ADDR_LINE_INVERT) begin
                next_cur.invert = wd[3:0];
            end else if (cur.aw_addr == ADDR_USER_SEL) begin
                next_cur.user_sel = wd[3:0];
            end else if (cur.aw_addr == ADDR_USER_VALUE) begin
                next_cur.user_val = wd[3:0];
            end else if (cur.aw_addr == ADDR_LINE_STATUS) begin
                next_cur.bresp = RESP_OKAY;  // read only, write dropped
            end else begin
                next_cur.bresp = RESP_SLVERR;  // unmapped
            end
        end

        // AXI4-Lite read: one-cycle answer
        if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !cur.rvalid) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp = RESP_OKAY;
            next_cur.rdata = 32'h0000_0000;
            if (s_axi_araddr == ADDR_TIMER_SEL) begin
                next_cur.rdata[1:0] = cur.sel;
            end else if (s_axi_araddr == ADDR_START_SRC) begin
                next_cur.rdata[1:0] = cur.src[cur.sel];
            end else if (s_axi_araddr == ADDR_DELAY_COUNT) begin
                next_cur.rdata[11:0] = cur.dly[cur.sel];
            end else if (s_axi_araddr == ADDR_DELAY_BASE) begin
                next_cur.rdata[15:0] = cur.dly_base;
            end else if (s_axi_araddr == ADDR_DELAY_ABS) begin
                next_cur.rdata = abs_time(cur.dly[cur.sel], cur.dly_base);
            end else if (s_axi_araddr == ADDR_DUR_COUNT) begin
                next_cur.rdata[11:0] = cur.dur[cur.sel];
            end else if (s_axi_araddr == ADDR_DUR_BASE) begin
                next_cur.rdata[15:0] = cur.dur_base;
            end else if (s_axi_araddr == ADDR_DUR_ABS) begin
                next_cur.rdata = abs_time(cur.dur[cur.sel], cur.dur_base);
            end else if (s_axi_araddr == ADDR_LINE_INVERT) begin
                next_cur.rdata[3:0] = cur.invert;
            end else if (s_axi_araddr == ADDR_USER_SEL) begin
                next_cur.rdata[3:0] = cur.user_sel;
            end else if (s_axi_araddr == ADDR_USER_VALUE) begin
                next_cur.rdata[3:0] = cur.user_val;
            end else if (s_axi_araddr == ADDR_LINE_STATUS) begin
                next_cur.rdata[3:0] = cur.line;
                next_cur.rdata[7:4] = cur.timer_out;
            end else begin
                next_cur.rresp = RESP_SLVERR;  // unmapped
            end
        end
    end

    // =====================================================================
    // state register
    // =====================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur <= '0;
            for (int i = 0; i < 4; i++) begin
                cur.phase[i] <= T_IDLE;
                cur.dly[i] <= DELAY_COUNT_RESET;
                cur.dur[i] <= DUR_COUNT_RESET;
                cur.src[i] <= SRC_EXPOSURE_START;
            end
            cur.dly_base <= BASE_RESET;
            cur.dur_base <= BASE_RESET;
            cur.user_sel <= USER_SEL_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    // ready only while the holding slot is free and no write answer stands
    assign s_axi_awready = ~cur.aw_ok & ~cur.bvalid;
    assign s_axi_wready = ~cur.w_ok & ~cur.bvalid;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = ~cur.rvalid;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata = cur.rdata;
    assign s_axi_rresp = cur.rresp;
    assign out_line = cur.line;
endmodule : output_pulse_timers

/* hdl/output_pulse_timers_pkg.sv */
package output_pulse_timers_pkg;
    // =====================================================================
    // register map (byte addresses)
    // =====================================================================
    localparam logic [7:0] ADDR_TIMER_SEL = 8'h00;
    localparam logic [7:0] ADDR_START_SRC = 8'h04;
    localparam logic [7:0] ADDR_DELAY_COUNT = 8'h08;
    localparam logic [7:0] ADDR_DELAY_BASE = 8'h0c;
    localparam logic [7:0] ADDR_DELAY_ABS = 8'h10;
    localparam logic [7:0] ADDR_DUR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_DUR_BASE = 8'h18;
    localparam logic [7:0] ADDR_DUR_ABS = 8'h1c;
    localparam logic [7:0] ADDR_LINE_INVERT = 8'h20;
    localparam logic [7:0] ADDR_USER_SEL = 8'h24;
    localparam logic [7:0] ADDR_USER_VALUE = 8'h28;
    localparam logic [7:0] ADDR_LINE_STATUS = 8'h2c;
    // =====================================================================
    // fields and reset values
    // =====================================================================
    localparam int COUNT_W = 12;
    localparam int BASE_W = 16;
    localparam int ABS_W = 28;
    localparam logic [11:0] COUNT_MAX = 12'hfff;
    localparam logic [11:0] DELAY_COUNT_RESET = 12'h000;
    localparam logic [11:0] DUR_COUNT_RESET = 12'h001;
    localparam logic [15:0] BASE_RESET = 16'h0001;
    localparam logic [15:0] BASE_MIN = 16'h0001;
    localparam logic [1:0] SRC_EXPOSURE_START = 2'h1;
    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =====================================================================
    // timing
    // =====================================================================
    localparam int CLK_HZ = 25000000;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
    // line source selection: timer or user value
    localparam logic [3:0] USER_SEL_RESET = 4'h0;
endpackage : output_pulse_timers_pkg

/* sim/line_observer.sv */
`timescale 1ns/1ps
// external equipment: times each line against the exposure start it sees
module line_observer (
    input wire logic aclk,
    input wire logic start,
    input wire logic [3:0] line,
    output logic [3:0] done,
    output logic [15:0] lead [4],
    output logic [15:0] width [4]
);
    logic start_q = 1'b0; // start seen last cycle
    logic [3:0] busy = 4'h0; // line armed by a start
    logic [3:0] act = 4'h0; // line away from its idle level
    logic [3:0] idle; // level at start, so inversion needs no setting here
    logic [15:0] cnt [4]; // cycles in current phase
    // =====================================================================
    // phase timing; a start while armed is not taken, like a real scope
    // =====================================================================
    always @(posedge aclk) begin
        start_q <= start;
        for (int i = 0; i < 4; i++) begin
            done[i] <= 1'b0;
            if (!busy[i] && start && !start_q) begin
                busy[i] <= 1'b1;
                act[i] <= 1'b0;
                cnt[i] <= 16'h0001;
                idle[i] <= line[i];
            end else if (busy[i]) begin
                cnt[i] <= cnt[i] + 16'h0001;
                if (!act[i] && line[i] != idle[i]) begin
                    lead[i] <= cnt[i];
                    cnt[i] <= 16'h0001;
                    act[i] <= 1'b1;
                end else if (act[i] && line[i] == idle[i]) begin
                    width[i] <= cnt[i];
                    done[i] <= 1'b1;
                    busy[i] <= 1'b0;
                end
            end
        end
    end
endmodule : line_observer

/* sim/output_pulse_timers_sva.sv */
`timescale 1ns/1ps
module output_pulse_timers_sva
    import output_pulse_timers_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] out_line
);
    // =====================================================================
    // bus and line checks, one clock domain
    // =====================================================================
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // both halves taken together in this bench, so the pair is the cause
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    a_rd_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while answering");
    a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && !s_axi_bvalid)
        else $error("write side not reopened");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    // reset itself is the cause here, so this one is never disabled
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> out_line == 4'h0 && !s_axi_bvalid)
        else $error("outputs not quiet after reset");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_line: cover property ($rose(out_line[0]));
endmodule : output_pulse_timers_sva

/* sim/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
bind output_pulse_timers output_pulse_timers_sva chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .out_line);
module tb;
    import output_pulse_timers_pkg::*;
    typedef struct {int d; int w;} note_t;
    logic aclk = 1'b0, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, exposure_start;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, ed;
    logic [3:0] wstrb, out_line, done;
    logic [1:0] bresp, rresp, er;
    logic [15:0] lead [4], width [4];
    logic [31:0] rq_d [$]; // expected read data, oldest first
    logic [1:0] rq_r [$], bq [$]; // expected response codes
    note_t pq [4][$]; // expected pulses per line, in microseconds
    note_t n;
    int errors = 0, cmp_count = 0, cyc = 0, seed, q, dl [4], du [4];
    always #20 aclk = ~aclk; // 25 MHz
    output_pulse_timers uut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .exposure_start, .out_line);
    line_observer peer (.aclk, .start(exposure_start), .line(out_line), .done, .lead, .width);
    // =====================================================================
    // bus master; an edge passes first so no strobe is set twice at once
    // =====================================================================
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        rq_d.push_back(d);
        rq_r.push_back(r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
    endtask : rd
    task automatic fire;
        @(posedge aclk) exposure_start <= 1'b1;
        repeat (4) @(posedge aclk);
        exposure_start <= 1'b0;
    endtask : fire
    // two starts close together; only the first may count
    task automatic run(input int base, input logic [3:0] mask);
        for (int i = 0; i < 4; i++) if (mask[i]) pq[i].push_back('{dl[i] * base, du[i]});
        `CHK("idle", 4'h5, out_line)
        fire();
        repeat (3) @(posedge aclk);
        fire();
        repeat (900) @(posedge aclk);
    endtask : run
    task automatic summarize;
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // =====================================================================
    // result watcher: each answer is judged against the oldest note
    // =====================================================================
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
        if (bvalid && bready) begin
            er = bq.pop_front();
            `CHK("bresp", er, bresp)
        end
        if (rvalid && rready) begin
            ed = rq_d.pop_front();
            er = rq_r.pop_front();
            `CHK("rdata", ed, rdata)
            `CHK("rresp", er, rresp)
        end
        for (int i = 0; i < 4; i++) if (done[i]) begin
            if (pq[i].size() == 0) `CHK("pulse", 1'b0, 1'b1)
            else begin
                n = pq[i].pop_front();
                q = lead[i] / 25;
                `CHK("lead", 1'b1, q >= n.d && q <= n.d + 1)
                `CHK("width", n.w, (width[i] + 12) / 25)
            end
        end
    end
    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        seed = 39;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, exposure_start} = 7'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_START_SRC, 32'h1, RESP_OKAY);
        rd(ADDR_DELAY_COUNT, 32'h0, RESP_OKAY);
        rd(ADDR_DELAY_BASE, 32'h1, RESP_OKAY);
        rd(ADDR_DUR_COUNT, 32'h1, RESP_OKAY);
        rd(ADDR_DUR_BASE, 32'h1, RESP_OKAY);
        rd(ADDR_LINE_INVERT, 32'h0, RESP_OKAY);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h30, 32'h1, RESP_SLVERR);
        wr(ADDR_DELAY_BASE, 32'h3, RESP_OKAY);
        wr(ADDR_DELAY_ABS, 32'ha, RESP_OKAY);
        rd(ADDR_DELAY_ABS, 32'h9, RESP_OKAY);
        wr(ADDR_DELAY_ABS, 32'hb, RESP_OKAY);
        rd(ADDR_DELAY_COUNT, 32'h4, RESP_OKAY);
        wr(ADDR_DELAY_COUNT, 32'hfff, RESP_OKAY);
        rd(ADDR_DELAY_ABS, 32'h2ffd, RESP_OKAY);
        wr(ADDR_DUR_COUNT, 32'h0, RESP_OKAY);
        rd(ADDR_DUR_COUNT, 32'h1, RESP_OKAY);
        wr(ADDR_DUR_BASE, 32'h5, RESP_OKAY);
        wr(ADDR_DUR_COUNT, 32'h7, RESP_OKAY);
        rd(ADDR_DUR_ABS, 32'h23, RESP_OKAY);
        wr(ADDR_DUR_BASE, 32'h1, RESP_OKAY);
        wr(ADDR_DELAY_BASE, 32'h2, RESP_OKAY);
        wr(ADDR_LINE_INVERT, 32'h5, RESP_OKAY);
        rd(ADDR_LINE_STATUS, 32'h5, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            dl[i] = (i == 0) ? 0 : $random(seed) & 7;
            du[i] = ($random(seed) & 7) + 1;
            wr(ADDR_TIMER_SEL, 32'(i), RESP_OKAY);
            wr(ADDR_DELAY_COUNT, 32'(dl[i]), RESP_OKAY);
            wr(ADDR_DUR_COUNT, 32'(du[i]), RESP_OKAY);
        end
        run(2, 4'hf);
        wr(ADDR_DELAY_BASE, 32'h1, RESP_OKAY);
        wr(ADDR_START_SRC, 32'h0, RESP_OKAY);
        run(1, 4'h7);
        wr(ADDR_USER_VALUE, 32'h3, RESP_OKAY);
        wr(ADDR_USER_SEL, 32'h3, RESP_OKAY);
        rd(ADDR_USER_VALUE, 32'h3, RESP_OKAY);
        rd(ADDR_LINE_STATUS, 32'h6, RESP_OKAY);
        for (int i = 0; i < 4; i++) `CHK("left", 0, pq[i].size())
        summarize();
    end
endmodule : tb
